/* File: design/port_pin_function_steering.sv */
// port pin control with alternate function steering, apb register slave
// assumes peripherals on core_clk; pins asynchronous, resolved by the bench
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_steering
  import pin_steer_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // pins, three signals each
  input  wire logic [7:0]        pin_a_in,
  input  wire logic [7:0]        pin_b_in,
  input  wire logic [7:0]        pin_c_in,
  output var  logic [7:0]        pin_a_out,
  output var  logic [7:0]        pin_b_out,
  output var  logic [7:0]        pin_c_out,
  output var  logic [7:0]        pin_a_oe,
  output var  logic [7:0]        pin_b_oe,
  output var  logic [7:0]        pin_c_oe,
  // peripheral side
  input  wire periph_bundle_type periph_out,
  output var  periph_in_type     periph_in
);

  if (PORT_WIDTH != 8) begin : g_bad_width
    $error("port width must be 8");
  end

  // ==========================================================================
  // registers
  logic [7:0] steer_reg;
  logic [7:0] dir_a_reg, dir_b_reg, dir_c_reg;
  logic [7:0] lat_a_reg, lat_b_reg, lat_c_reg;
  logic [7:0] ansel_a_reg, ansel_b_reg;
  logic [7:0] pin_a_sync, pin_b_sync, pin_c_sync;
  logic [7:0] dig_a, dig_b, dig_c;
  logic       wr_en;
  logic       access;

  assign access = psel && penable && pready;
  assign wr_en  = access && pwrite;

  // ==========================================================================
  // steering, reset to defaults
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      steer_reg <= STEER_RESET;
    end else if (wr_en && paddr == STEER_OFFSET) begin
      steer_reg <= pwdata[7:0] & STEER_MASK;
    end
  end

  // direction registers written only at their own offsets
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dir_a_reg <= DIR_RESET;
      dir_b_reg <= DIR_RESET;
      dir_c_reg <= DIR_RESET;
    end else if (wr_en) begin
      // steering writes never land here
      if (paddr == DIR_A_OFFSET) dir_a_reg <= pwdata[7:0];
      if (paddr == DIR_B_OFFSET) dir_b_reg <= pwdata[7:0];
      if (paddr == DIR_C_OFFSET) dir_c_reg <= pwdata[7:0];
    end
  end

  // pin data and latch offsets both write the latch
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lat_a_reg <= LAT_RESET;
      lat_b_reg <= LAT_RESET;
      lat_c_reg <= LAT_RESET;
    end else if (wr_en) begin
      if (paddr == LAT_A_OFFSET || paddr == PIN_A_OFFSET) lat_a_reg <= pwdata[7:0];
      if (paddr == LAT_B_OFFSET || paddr == PIN_B_OFFSET) lat_b_reg <= pwdata[7:0];
      if (paddr == LAT_C_OFFSET || paddr == PIN_C_OFFSET) lat_c_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ansel_a_reg <= ANSEL_A_RESET;
      ansel_b_reg <= ANSEL_B_RESET;
    end else if (wr_en) begin
      if (paddr == ANSEL_A_OFFSET) ansel_a_reg <= pwdata[7:0] & ANSEL_A_MASK;
      if (paddr == ANSEL_B_OFFSET) ansel_b_reg <= pwdata[7:0] & ANSEL_B_MASK;
    end
  end

  // ==========================================================================
  // input path
  pin_sync3 #(.WIDTH(24)) u_sync (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pin_async ({pin_c_in, pin_b_in, pin_a_in}),
    .pin_sync  ({pin_c_sync, pin_b_sync, pin_a_sync})
  );

  // analog pins gate the digital buffer and read zero
  assign dig_a = pin_a_sync & ~ansel_a_reg;
  assign dig_b = pin_b_sync & ~ansel_b_reg;
  assign dig_c = pin_c_sync;

  // steered inputs; unselected pin keeps only its port role
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      periph_in <= '{timer_gate_in: 1'b0, slave_select_n: 1'b1};
    end else begin
      periph_in.timer_gate_in  <= steer_reg[TGATE_SEL_BIT] ? dig_c[4] : dig_b[5];
      periph_in.slave_select_n <= steer_reg[SLAVE_SEL_BIT] ? dig_a[0] : dig_a[5];
    end
  end

  // ==========================================================================
  // output path: lowest priority is the port latch
  logic [7:0] ovr_en_a, ovr_en_b, ovr_en_c;
  logic [7:0] ovr_lv_a, ovr_lv_b, ovr_lv_c;
  logic       s_c2, s_c3, s_p2b, s_nq, s_cmp;

  assign s_c2  = steer_reg[CAPTURE2_SEL_BIT];
  assign s_c3  = steer_reg[CAPTURE3_SEL_BIT];
  assign s_p2b = steer_reg[PWM2B_SEL_BIT];
  assign s_nq  = steer_reg[LATCH_NQ_SEL_BIT];
  assign s_cmp = steer_reg[COMP2_SEL_BIT];

  // latch nq outranks comparator output on a shared pin
  always_comb begin
    ovr_en_a = 8'h00;
    ovr_lv_a = 8'h00;
    ovr_en_b = 8'h00;
    ovr_lv_b = 8'h00;
    ovr_en_c = 8'h00;
    ovr_lv_c = 8'h00;
    if (periph_out.comparator2_out.enable) begin
      ovr_en_a[s_cmp ? 0 : 5] = 1'b1;
      ovr_lv_a[s_cmp ? 0 : 5] = periph_out.comparator2_out.level;
    end
    if (periph_out.latch_inverted_out.enable) begin
      ovr_en_a[s_nq ? 0 : 5] = 1'b1;
      ovr_lv_a[s_nq ? 0 : 5] = periph_out.latch_inverted_out.level;
    end
    if (periph_out.capture2_pwm_a.enable) begin
      if (s_c2) begin
        ovr_en_b[3] = 1'b1;
        ovr_lv_b[3] = periph_out.capture2_pwm_a.level;
      end else begin
        ovr_en_c[1] = 1'b1;
        ovr_lv_c[1] = periph_out.capture2_pwm_a.level;
      end
    end
    if (periph_out.pwm2_b_out.enable) begin
      if (s_p2b) begin
        ovr_en_b[5] = 1'b1;
        ovr_lv_b[5] = periph_out.pwm2_b_out.level;
      end else begin
        ovr_en_c[0] = 1'b1;
        ovr_lv_c[0] = periph_out.pwm2_b_out.level;
      end
    end
    if (periph_out.capture3_pwm_a.enable) begin
      if (s_c3) begin
        ovr_en_b[5] = 1'b1;
        ovr_lv_b[5] = periph_out.capture3_pwm_a.level;
      end else begin
        ovr_en_c[6] = 1'b1;
        ovr_lv_c[6] = periph_out.capture3_pwm_a.level;
      end
    end
  end

  // direction still governs the driver; peripheral replaces the latch value
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_a_oe  <= 8'h00;
      pin_b_oe  <= 8'h00;
      pin_c_oe  <= 8'h00;
      pin_a_out <= 8'h00;
      pin_b_out <= 8'h00;
      pin_c_out <= 8'h00;
    end else begin
      pin_a_oe  <= ~dir_a_reg;
      pin_b_oe  <= ~dir_b_reg;
      pin_c_oe  <= ~dir_c_reg;
      pin_a_out <= (ovr_en_a & ovr_lv_a) | (~ovr_en_a & lat_a_reg);
      pin_b_out <= (ovr_en_b & ovr_lv_b) | (~ovr_en_b & lat_b_reg);
      pin_c_out <= (ovr_en_c & ovr_lv_c) | (~ovr_en_c & lat_c_reg);
    end
  end

  // ==========================================================================
  // apb: one wait state, read data registered
  logic [7:0]  rd_byte;
  logic        rd_hit;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (paddr)
      STEER_OFFSET:     rd_byte = steer_reg & STEER_MASK;
      DIR_A_OFFSET:     rd_byte = dir_a_reg;
      DIR_B_OFFSET:     rd_byte = dir_b_reg;
      DIR_C_OFFSET:     rd_byte = dir_c_reg;
      PIN_A_OFFSET:     rd_byte = dig_a;
      PIN_B_OFFSET:     rd_byte = dig_b;
      PIN_C_OFFSET:     rd_byte = dig_c;
      LAT_A_OFFSET:     rd_byte = lat_a_reg;
      LAT_B_OFFSET:     rd_byte = lat_b_reg;
      LAT_C_OFFSET:     rd_byte = lat_c_reg;
      ANSEL_A_OFFSET:   rd_byte = ansel_a_reg;
      ANSEL_B_OFFSET:   rd_byte = ansel_b_reg;
      PERIPH_EN_OFFSET: rd_byte = {3'b000, periph_out.comparator2_out.enable,
                                   periph_out.latch_inverted_out.enable,
                                   periph_out.pwm2_b_out.enable,
                                   periph_out.capture3_pwm_a.enable,
                                   periph_out.capture2_pwm_a.enable} & PERIPH_MASK;
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // unmapped or write to a read-only offset
      pslverr <= psel && penable && !pready
                 && (!rd_hit || (pwrite && paddr == PERIPH_EN_OFFSET));
    end
  end

  // ==========================================================================
  // checks
  a_steer_top_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    steer_reg[7] == 1'b0) else $error("steering top bit set");

  a_steer_keeps_dir: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && paddr == STEER_OFFSET |=> $stable(dir_a_reg) && $stable(dir_b_reg)
    && $stable(dir_c_reg)) else $error("steering write changed direction");

  a_pin_write_latch: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && paddr == PIN_A_OFFSET |=> lat_a_reg == $past(pwdata[7:0]))
    else $error("pin data write missed the latch");

  a_latch_read_back: assert property (@(posedge core_clk) disable iff (!resetn)
    psel && penable && !pready && !pwrite && paddr == LAT_B_OFFSET
    |=> pready && prdata[7:0] == $past(lat_b_reg))
    else $error("latch read mismatch");

  a_analog_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    psel && penable && !pready && !pwrite && paddr == PIN_A_OFFSET
    |=> (prdata[7:0] & $past(ansel_a_reg)) == 8'h00)
    else $error("analog pin read nonzero");

  a_dir_drives_oe: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(resetn) |-> pin_c_oe == ~$past(dir_c_reg))
    else $error("driver enable not from direction");

  a_cap2_on_b3: assert property (@(posedge core_clk) disable iff (!resetn)
    s_c2 && periph_out.capture2_pwm_a.enable && !ovr_en_c[1] |=>
    pin_b_out[3] == $past(periph_out.capture2_pwm_a.level)
    && pin_c_out[1] == $past(lat_c_reg[1]))
    else $error("capture2 misrouted");

  a_gate_from_c4: assert property (@(posedge core_clk) disable iff (!resetn)
    steer_reg[TGATE_SEL_BIT] |=> periph_in.timer_gate_in == $past(dig_c[4]))
    else $error("timer gate misrouted");

  a_ss_from_a5: assert property (@(posedge core_clk) disable iff (!resetn)
    !steer_reg[SLAVE_SEL_BIT] |=> periph_in.slave_select_n == $past(dig_a[5]))
    else $error("slave select misrouted");

  a_steer_reset: assert property (@(posedge core_clk)
    !resetn |=> steer_reg == 8'h00) else $error("steering not reset");

endmodule // port_pin_function_steering
`default_nettype wire

/* File: inc/pin_steer_pkg.sv */
// package for the port pin control and function steering block
// assumes an apb slave at 32-bit word addresses, ports a, b, c of 8 pins
package pin_steer_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] STEER_OFFSET      = 12'h000;
  localparam logic [11:0] DIR_A_OFFSET      = 12'h010;
  localparam logic [11:0] DIR_B_OFFSET      = 12'h014;
  localparam logic [11:0] DIR_C_OFFSET      = 12'h018;
  localparam logic [11:0] PIN_A_OFFSET      = 12'h020;
  localparam logic [11:0] PIN_B_OFFSET      = 12'h024;
  localparam logic [11:0] PIN_C_OFFSET      = 12'h028;
  localparam logic [11:0] LAT_A_OFFSET      = 12'h030;
  localparam logic [11:0] LAT_B_OFFSET      = 12'h034;
  localparam logic [11:0] LAT_C_OFFSET      = 12'h038;
  localparam logic [11:0] ANSEL_A_OFFSET    = 12'h040;
  localparam logic [11:0] ANSEL_B_OFFSET    = 12'h044;
  localparam logic [11:0] PERIPH_EN_OFFSET  = 12'h050;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] STEER_RESET   = 8'h00;
  localparam logic [7:0] DIR_RESET     = 8'hFF;
  localparam logic [7:0] LAT_RESET     = 8'h00;
  localparam logic [7:0] ANSEL_A_RESET = 8'h3F;
  localparam logic [7:0] ANSEL_B_RESET = 8'h3F;
  localparam logic [7:0] STEER_MASK    = 8'h7F;
  localparam logic [7:0] ANSEL_A_MASK  = 8'h3F;
  localparam logic [7:0] ANSEL_B_MASK  = 8'h3F;
  localparam logic [7:0] PERIPH_MASK   = 8'h1F;

  // ==========================================================================
  // steering bit positions
  localparam int CAPTURE2_SEL_BIT = 0;
  localparam int SLAVE_SEL_BIT    = 1;
  localparam int COMP2_SEL_BIT    = 2;
  localparam int LATCH_NQ_SEL_BIT = 3;
  localparam int PWM2B_SEL_BIT    = 4;
  localparam int TGATE_SEL_BIT    = 5;
  localparam int CAPTURE3_SEL_BIT = 6;

  // peripheral output enable bit positions
  localparam int EN_CAPTURE2 = 0;
  localparam int EN_CAPTURE3 = 1;
  localparam int EN_PWM2B    = 2;
  localparam int EN_LATCH_NQ = 3;
  localparam int EN_COMP2    = 4;

  // one peripheral output: level plus enable
  typedef struct packed {
    logic level;
    logic enable;
  } periph_out_type;

  // all steerable peripheral outputs
  typedef struct packed {
    periph_out_type capture2_pwm_a;
    periph_out_type capture3_pwm_a;
    periph_out_type pwm2_b_out;
    periph_out_type latch_inverted_out;
    periph_out_type comparator2_out;
  } periph_bundle_type;

  // steered inputs towards peripherals
  typedef struct packed {
    logic timer_gate_in;
    logic slave_select_n;
  } periph_in_type;

endpackage

/* File: design/pin_sync3.sv */
// three-stage pin synchroniser with agreement of stages two and three
// assumes pins asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sync3
  import pin_steer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_async,
  output var  logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync3 width must be positive");
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_agree
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          pin_sync[i] <= 1'b0;
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          pin_sync[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync3
`default_nettype wire

/* File: verif/pin_partner.sv */
// external pin model: resolves each pin from the block's drive and the board
// assumes ports a, b, c packed as {c, b, a}, 8 pins each
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic [23:0] drv,
  input  wire logic [23:0] oe,
  input  wire logic [23:0] ext,
  output var  logic [23:0] lvl
);
  // ==========================================================
  // wire resolution
  // the block wins while driving, the board level otherwise
  always_comb lvl = (drv & oe) | (ext & ~oe);
endmodule // pin_partner
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench: apb register tests plus pin and steering checks
// assumes the block's apb slave answers with one wait state
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pin_steer_pkg::*;
  logic              core_clk = 1'h0;
  logic              resetn   = 1'h0;
  logic              psel     = 1'h0;
  logic              penable  = 1'h0;
  logic              pwrite   = 1'h0;
  logic [11:0]       paddr    = 12'h000;
  logic [31:0]       pwdata   = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  wire [23:0]        pin_lvl;
  wire [23:0]        pin_out;
  wire [23:0]        pin_oe;
  logic [23:0]       ext      = 24'h0000C3;
  periph_bundle_type periph_out = '0;
  periph_in_type     periph_in;
  int                errors   = 0;
  int                tests_run = 0;
  int                cycles   = 0;
  logic [31:0]       r;
  logic              e;
  int                sel_bit [5] = '{0, 6, 4, 3, 2};
  int                pin_dflt[5] = '{17, 22, 16, 5, 5};
  int                pin_alt [5] = '{11, 13, 13, 0, 0};

  always #5 core_clk = ~core_clk;

  port_pin_function_steering dut_u (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .pin_a_in  (pin_lvl[7:0]),
    .pin_b_in  (pin_lvl[15:8]),
    .pin_c_in  (pin_lvl[23:16]),
    .pin_a_out (pin_out[7:0]),
    .pin_b_out (pin_out[15:8]),
    .pin_c_out (pin_out[23:16]),
    .pin_a_oe  (pin_oe[7:0]),
    .pin_b_oe  (pin_oe[15:8]),
    .pin_c_oe  (pin_oe[23:16]),
    .periph_out(periph_out),
    .periph_in (periph_in)
  );

  pin_partner partner_u (
    .drv(pin_out),
    .oe (pin_oe),
    .ext(ext),
    .lvl(pin_lvl)
  );

  // ==========================================================
  // verdict and hang guard
  task automatic complete_run;
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run;
    end
  end

  // ==========================================================
  // apb master and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'h0, a, 32'h0);
    chk(r, {24'h0, exp});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'h1;
    rd(STEER_OFFSET, 8'h00);
    rd(DIR_A_OFFSET, 8'hFF);
    rd(ANSEL_A_OFFSET, 8'h3F);
    wr(STEER_OFFSET, 8'hFF);
    rd(STEER_OFFSET, 8'h7F);
    rd(DIR_B_OFFSET, 8'hFF);
    wr(ANSEL_A_OFFSET, 8'h00);
    wr(ANSEL_B_OFFSET, 8'h00);
    wr(LAT_A_OFFSET, 8'h5A);
    wr(DIR_A_OFFSET, 8'h00);
    rd(LAT_A_OFFSET, 8'h5A);
    chk({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'hFF5A);
    repeat (8) @(posedge core_clk);
    rd(PIN_A_OFFSET, 8'h5A);
    wr(DIR_A_OFFSET, 8'hFF);
    repeat (8) @(posedge core_clk);
    chk({24'h0, pin_oe[7:0]}, 32'h0);
    rd(PIN_A_OFFSET, 8'hC3);
    rd(LAT_A_OFFSET, 8'h5A);
    wr(PIN_A_OFFSET, 8'h3C);
    rd(LAT_A_OFFSET, 8'h3C);
    wr(ANSEL_A_OFFSET, 8'h0F);
    repeat (8) @(posedge core_clk);
    rd(PIN_A_OFFSET, 8'hC0);
    // overrides: latches high, peripheral drives low on one pin only
    wr(LAT_A_OFFSET, 8'hFF);
    wr(LAT_B_OFFSET, 8'hFF);
    wr(LAT_C_OFFSET, 8'hFF);
    wr(DIR_A_OFFSET, 8'h00);
    wr(DIR_B_OFFSET, 8'h00);
    wr(DIR_C_OFFSET, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({8'h0, pin_oe}, 32'h00FF_FFFF);
    rd(LAT_B_OFFSET, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      periph_out <= periph_bundle_type'(10'h001 << (2 * (4 - i)));
      for (int s = 0; s < 2; s++) begin
        wr(STEER_OFFSET, 8'(s << sel_bit[i]));
        repeat (3) @(posedge core_clk);
        chk({8'h0, pin_out}, {8'h0, ~(24'h1 << (s ? pin_alt[i] : pin_dflt[i]))});
      end
    end
    // comparator still drives a0 low; a0 to a3 are analog and read zero
    repeat (4) @(posedge core_clk);
    rd(PIN_A_OFFSET, 8'hF0);
    rd(DIR_C_OFFSET, 8'h00);
    // steered inputs: a5 and b5 high, a0 and c4 low
    periph_out <= '0;
    wr(ANSEL_A_OFFSET, 8'h00);
    wr(DIR_A_OFFSET, 8'hFF);
    wr(DIR_B_OFFSET, 8'hFF);
    wr(DIR_C_OFFSET, 8'hFF);
    ext <= 24'h002020;
    for (int s = 0; s < 2; s++) begin
      wr(STEER_OFFSET, s ? 8'h22 : 8'h00);
      repeat (8) @(posedge core_clk);
      chk({30'h0, periph_in}, s ? 32'h0 : 32'h3);
    end
    rd(PIN_B_OFFSET, 8'h20);
    rd(PIN_C_OFFSET, 8'h00);
    // refused accesses
    apb(1'h0, 12'h0FC, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'h1, PERIPH_EN_OFFSET, 32'h0);
    chk({31'h0, e}, 32'h1);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
